/* File: logic/dop_clock_power_ctrl.sv */
// clock generator and power mode control for a two-oscillator controller
// assumes: clk_i is an always-on system clock; oscillator levels, timer pin,
// external interrupt pins and the power-up indication are asynchronous
//
// Functional notes
// - osc control bit 2 picks timer0 clock: pin when clear, subclock when set
// - osc control bit 1 runs low oscillator; loaded from fuse after reset
// - osc control bit 0 runs high oscillator; loaded from fuse after reset
// - reload register holds 8-bit prescaler value, resets to all ones
// - FFh divides by 2 or 1; else 4 or 2 times (255-reload)
// - power-off flag set at power-up; software may set or clear it
// - power control bits 3 and 2 are plain software flags
// - bit 7 doubles baud rate; bit 6 selects framing view
// - writing one to bit 1 enters power-down; external or keyboard interrupt or reset clears it
// - writing one to bit 0 enters idle; interrupt or reset clears it
// - fuse one: high oscillator on, low off, high source selected
// - fuse zero: low oscillator on, high off, low source selected
// - clock source bit may switch cpu clock at any time
// - idle stops cpu clock, selected oscillator keeps peripherals clocked
// - leaving idle keeps oscillator enables and source select unchanged
// - power-down stops both oscillators regardless of enables
// - power-down wins over idle; cpu and peripheral clocks off
// - power-down left by reset, external or keyboard interrupt, or a write clearing bit 1
// - reset out of power-down restarts with fuse configuration
// - keyboard wake clears power-down and restarts the chosen oscillator
// - oscillator stop asserted in power-down or when enable is clear
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`include "dop_map.svh"
module dop_clock_power_ctrl #(
  parameter int CNT_W = 10
) (
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  input  wire logic                  ce_i,
  input  wire dop_pkg::dop_bus_req_t bus_i,
  output logic [7:0]                 rdata_o,
  input  wire logic                  fuse_osc_select_i,
  input  wire logic                  power_up_i,
  input  wire logic                  hf_osc_clk_i,
  input  wire logic                  lf_osc_clk_i,
  input  wire logic                  t0_pin_i,
  input  wire logic                  ext_irq_a_n_i,
  input  wire logic                  ext_irq_b_n_i,
  input  wire logic                  ext_irq_a_en_i,
  input  wire logic                  ext_irq_b_en_i,
  input  wire logic                  kbd_wake_i,
  input  wire logic                  irq_wake_i,
  output dop_pkg::dop_osc_ctl_t      osc_o,
  output dop_pkg::dop_clk_out_t      clk_o,
  output logic                       baud_doubler_o,
  output logic                       framing_view_select_o,
  output dop_pkg::dop_mode_t         mode_o
);
  import dop_pkg::*;

  generate
    if (CNT_W < `DOP_DIV_MAX_W) begin : g_chk
      $error("prescaler counter too narrow");
    end
  endgenerate

  // =========================================================
  // state
  typedef struct packed {
    logic       loaded;
    logic       timer0_subclock_select;
    logic       low_freq_osc_run;
    logic       high_freq_osc_run;
    logic       clock_source_hf;
    logic [7:0] prescaler_reload;
    logic       x2_mode;
    logic       baud_doubler;
    logic       framing_view_select;
    logic       power_off_flag;
    logic       user_flag_1;
    logic       user_flag_0;
    logic       power_down_request;
    logic       cpu_sleep_request;
    dop_mode_t  mode;
    logic [1:0] hf_sync;
    logic [1:0] lf_sync;
    logic [1:0] t0_sync;
    logic [1:0] irq_a_sync;
    logic [1:0] irq_b_sync;
    logic [1:0] pwr_sync;
    logic [7:0] rdata;
    logic       high_osc_stop;
    logic       low_osc_stop;
    logic       cpu_clk_en;
    logic       periph_clk_en;
    logic       timer0_clk;
  } dop_top_state_t;

  dop_top_state_t cur_r;
  dop_top_state_t cur_nxt;

  logic src_lvl;
  logic src_rise;
  logic tick;

  // =========================================================
  // register views
  function automatic logic [7:0] power_view(input dop_top_state_t s);
    power_view                = `DOP_BYTE_ZERO;
    power_view[`DOP_PC_BAUD2] = s.baud_doubler;
    power_view[`DOP_PC_FVIEW] = s.framing_view_select;
    power_view[`DOP_PC_POF]   = s.power_off_flag;
    power_view[`DOP_PC_UF1]   = s.user_flag_1;
    power_view[`DOP_PC_UF0]   = s.user_flag_0;
    power_view[`DOP_PC_PD]    = s.power_down_request;
    power_view[`DOP_PC_IDL]   = s.cpu_sleep_request;
  endfunction

  function automatic logic [7:0] osc_view(input dop_top_state_t s);
    osc_view                = `DOP_BYTE_ZERO;
    osc_view[`DOP_OC_T0SUB] = s.timer0_subclock_select;
    osc_view[`DOP_OC_LFRUN] = s.low_freq_osc_run;
    osc_view[`DOP_OC_HFRUN] = s.high_freq_osc_run;
  endfunction

  // =========================================================
  // source changeover and prescaler
  dop_clk_switch u_switch (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .ce_i      (ce_i),
    .hf_lvl_i  (cur_r.hf_sync[1]),
    .lf_lvl_i  (cur_r.lf_sync[1]),
    .sel_hf_i  (cur_r.clock_source_hf),
    .clk_lvl_o (src_lvl),
    .rise_o    (src_rise)
  );

  dop_prescaler #(
    .CNT_W (CNT_W)
  ) u_prescaler (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .ce_i     (ce_i),
    .edge_i   (src_rise),
    .reload_i (cur_r.prescaler_reload),
    .x2_i     (cur_r.x2_mode),
    .tick_o   (tick)
  );

  // =========================================================
  // next state
  always_comb begin
    logic wake_pd;
    logic wr;
    logic [7:0] d;
    cur_nxt = cur_r;
    wr      = bus_i.we;
    d       = bus_i.wdata;

    // pin synchronisers
    cur_nxt.hf_sync    = {cur_r.hf_sync[0], hf_osc_clk_i};
    cur_nxt.lf_sync    = {cur_r.lf_sync[0], lf_osc_clk_i};
    cur_nxt.t0_sync    = {cur_r.t0_sync[0], t0_pin_i};
    cur_nxt.irq_a_sync = {cur_r.irq_a_sync[0], ext_irq_a_n_i};
    cur_nxt.irq_b_sync = {cur_r.irq_b_sync[0], ext_irq_b_n_i};
    cur_nxt.pwr_sync   = {cur_r.pwr_sync[0], power_up_i};

    // fuse load after reset release
    if (!cur_r.loaded) begin
      cur_nxt.loaded            = 1'b1;
      cur_nxt.high_freq_osc_run = fuse_osc_select_i;
      cur_nxt.low_freq_osc_run  = !fuse_osc_select_i;
      cur_nxt.clock_source_hf   = fuse_osc_select_i;
    end

    // software writes
    if (wr && cur_r.loaded) begin
      case (bus_i.addr)
        `DOP_OFS_CLK_SOURCE: begin
          cur_nxt.clock_source_hf = d[`DOP_CS_CKS];
        end
        `DOP_OFS_OSC_CTRL: begin
          cur_nxt.timer0_subclock_select = d[`DOP_OC_T0SUB];
          cur_nxt.low_freq_osc_run       = d[`DOP_OC_LFRUN];
          cur_nxt.high_freq_osc_run      = d[`DOP_OC_HFRUN];
        end
        `DOP_OFS_RELOAD: begin
          cur_nxt.prescaler_reload = d;
        end
        `DOP_OFS_SPEED_CTRL0: begin
          cur_nxt.x2_mode = d[`DOP_SC_X2];
        end
        `DOP_OFS_POWER_CTRL: begin
          cur_nxt.baud_doubler        = d[`DOP_PC_BAUD2];
          cur_nxt.framing_view_select = d[`DOP_PC_FVIEW];
          cur_nxt.power_off_flag      = d[`DOP_PC_POF];
          cur_nxt.user_flag_1         = d[`DOP_PC_UF1];
          cur_nxt.user_flag_0         = d[`DOP_PC_UF0];
          cur_nxt.power_down_request  = d[`DOP_PC_PD];
          cur_nxt.cpu_sleep_request   = d[`DOP_PC_IDL];
        end
        default: begin
        end
      endcase
    end

    // hardware events win over a same-cycle write
    if (cur_r.pwr_sync[1]) begin
      cur_nxt.power_off_flag = 1'b1;
    end

    wake_pd = (ext_irq_a_en_i && !cur_r.irq_a_sync[1])
            || (ext_irq_b_en_i && !cur_r.irq_b_sync[1])
            || kbd_wake_i;
    if (cur_r.power_down_request && wake_pd) begin
      cur_nxt.power_down_request = 1'b0;
      cur_nxt.cpu_sleep_request  = 1'b0;
    end else if (cur_r.cpu_sleep_request && !cur_r.power_down_request && irq_wake_i) begin
      cur_nxt.cpu_sleep_request = 1'b0;
    end

    // mode, power-down first
    if (cur_nxt.power_down_request) begin
      cur_nxt.mode = DOP_PDOWN;
    end else if (cur_nxt.cpu_sleep_request) begin
      cur_nxt.mode = DOP_IDLE;
    end else begin
      cur_nxt.mode = DOP_NORMAL;
    end

    // oscillator stops
    if (!cur_nxt.loaded) begin
      cur_nxt.high_osc_stop = 1'b1;
      cur_nxt.low_osc_stop  = 1'b1;
    end else begin
      cur_nxt.high_osc_stop = cur_nxt.power_down_request || !cur_nxt.high_freq_osc_run;
      cur_nxt.low_osc_stop  = cur_nxt.power_down_request || !cur_nxt.low_freq_osc_run;
    end

    // clock enables
    cur_nxt.cpu_clk_en    = tick && cur_r.loaded && (cur_r.mode == DOP_NORMAL);
    cur_nxt.periph_clk_en = tick && cur_r.loaded && (cur_r.mode != DOP_PDOWN);

    // timer0 clock input
    cur_nxt.timer0_clk = cur_r.timer0_subclock_select ? cur_r.lf_sync[1] : cur_r.t0_sync[1];

    // readback, valid one cycle after the strobe
    cur_nxt.rdata = `DOP_BYTE_ZERO;
    if (bus_i.re) begin
      case (bus_i.addr)
        `DOP_OFS_CLK_SOURCE:  cur_nxt.rdata[`DOP_CS_CKS] = cur_r.clock_source_hf;
        `DOP_OFS_OSC_CTRL:    cur_nxt.rdata = osc_view(cur_r);
        `DOP_OFS_RELOAD:      cur_nxt.rdata = cur_r.prescaler_reload;
        `DOP_OFS_SPEED_CTRL0: cur_nxt.rdata[`DOP_SC_X2] = cur_r.x2_mode;
        `DOP_OFS_POWER_CTRL:  cur_nxt.rdata = power_view(cur_r);
        default:              cur_nxt.rdata = `DOP_BYTE_ZERO;
      endcase
    end
  end

  // =========================================================
  // registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cur_r                  <= '0;
      cur_r.prescaler_reload <= `DOP_RELOAD_RST;
      cur_r.mode             <= DOP_NORMAL;
      cur_r.high_osc_stop    <= 1'b1;
      cur_r.low_osc_stop     <= 1'b1;
    end else if (ce_i) begin
      cur_r <= cur_nxt;
    end
  end

  // =========================================================
  // outputs
  assign rdata_o                = cur_r.rdata;
  assign osc_o.high_osc_stop    = cur_r.high_osc_stop;
  assign osc_o.low_osc_stop     = cur_r.low_osc_stop;
  assign clk_o.src_clk          = src_lvl;
  assign clk_o.cpu_clk_en       = cur_r.cpu_clk_en;
  assign clk_o.periph_clk_en    = cur_r.periph_clk_en;
  assign clk_o.timer0_clk       = cur_r.timer0_clk;
  assign baud_doubler_o         = cur_r.baud_doubler;
  assign framing_view_select_o  = cur_r.framing_view_select;
  assign mode_o                 = cur_r.mode;
endmodule

/* File: logic/dop_map.svh */
// register offsets, field positions, reset values and divider figures
// assumes: included by bare name after the package is compiled
`ifndef DOP_MAP_SVH
`define DOP_MAP_SVH

// ===========================================================
// register offsets
`define DOP_OFS_CLK_SOURCE    8'h85
`define DOP_OFS_OSC_CTRL      8'h86
`define DOP_OFS_POWER_CTRL    8'h87
`define DOP_OFS_SPEED_CTRL0   8'h8F
`define DOP_OFS_RELOAD        8'h97

// ===========================================================
// power_control fields
`define DOP_PC_BAUD2          7
`define DOP_PC_FVIEW          6
`define DOP_PC_POF            4
`define DOP_PC_UF1            3
`define DOP_PC_UF0            2
`define DOP_PC_PD             1
`define DOP_PC_IDL            0

// ===========================================================
// oscillator_control, clock source and speed fields
`define DOP_OC_T0SUB          2
`define DOP_OC_LFRUN          1
`define DOP_OC_HFRUN          0
`define DOP_CS_CKS            0
`define DOP_SC_X2             0

// ===========================================================
// reset values and divider figures
`define DOP_RELOAD_RST        8'hFF
`define DOP_RELOAD_TOP        8'hFF
`define DOP_DIV_STD_FAST      2
`define DOP_DIV_X2_FAST       1
`define DOP_DIV_STD_SHIFT     2
`define DOP_DIV_X2_SHIFT      1
`define DOP_DIV_MAX_W         10
`define DOP_BYTE_ZERO         8'h00

`endif

/* File: logic/dop_pkg.sv */
// types shared by the clock and power control block
// assumes: compiled before every module of the block
package dop_pkg;

  // =========================================================
  // operating mode, one-hot
  typedef enum logic [2:0] {
    DOP_NORMAL = 3'b001,
    DOP_IDLE   = 3'b010,
    DOP_PDOWN  = 3'b100
  } dop_mode_t;

  // =========================================================
  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } dop_bus_req_t;

  // oscillator hard block controls
  typedef struct packed {
    logic high_osc_stop;
    logic low_osc_stop;
  } dop_osc_ctl_t;

  // clocks and enables toward cpu and peripherals
  typedef struct packed {
    logic src_clk;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic timer0_clk;
  } dop_clk_out_t;

endpackage

/* File: logic/dop_clk_switch.sv */
// glitch-free changeover between two sampled oscillator levels
// assumes: levels already pass two flip-flops in the caller
`timescale 1ns/100ps
module dop_clk_switch (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic ce_i,
  input  wire logic hf_lvl_i,
  input  wire logic lf_lvl_i,
  input  wire logic sel_hf_i,
  output logic      clk_lvl_o,
  output logic      rise_o
);
  import dop_pkg::*;

  typedef struct packed {
    logic cur_hf;
    logic out;
    logic prev_hf;
    logic prev_lf;
    logic rise;
  } dop_sw_state_t;

  dop_sw_state_t cur_r;
  dop_sw_state_t cur_nxt;

  // =========================================================
  // changeover
  always_comb begin
    logic src;
    logic new_rise;
    src      = cur_r.cur_hf ? hf_lvl_i : lf_lvl_i;
    new_rise = sel_hf_i ? (hf_lvl_i && !cur_r.prev_hf) : (lf_lvl_i && !cur_r.prev_lf);
    cur_nxt         = cur_r;
    cur_nxt.prev_hf = hf_lvl_i;
    cur_nxt.prev_lf = lf_lvl_i;
    if (sel_hf_i != cur_r.cur_hf) begin
      if (cur_r.out && src) begin
        cur_nxt.out = 1'b1;
      end else begin
        cur_nxt.out = 1'b0;
        if (!cur_r.out && new_rise) begin
          cur_nxt.cur_hf = sel_hf_i;
          cur_nxt.out    = 1'b1;
        end
      end
    end else begin
      cur_nxt.out = src;
    end
    cur_nxt.rise = !cur_r.out && cur_nxt.out;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cur_r <= '{cur_hf: 1'b1, default: 1'b0};
    end else if (ce_i) begin
      cur_r <= cur_nxt;
    end
  end

  assign clk_lvl_o = cur_r.out;
  assign rise_o    = cur_r.rise;
endmodule

/* File: logic/dop_prescaler.sv */
// reload-driven divider of source clock edges
// assumes: edge_i is a one-cycle pulse per source rising edge
`timescale 1ns/100ps
`include "dop_map.svh"
module dop_prescaler #(
  parameter int CNT_W = 10
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       ce_i,
  input  wire logic       edge_i,
  input  wire logic [7:0] reload_i,
  input  wire logic       x2_i,
  output logic            tick_o
);
  import dop_pkg::*;

  generate
    if (CNT_W < `DOP_DIV_MAX_W) begin : g_chk
      $error("prescaler counter too narrow");
    end
  endgenerate

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } dop_ps_state_t;

  dop_ps_state_t cur_r;
  dop_ps_state_t cur_nxt;

  // =========================================================
  // divisor from reload and speed mode
  function automatic logic [CNT_W-1:0] div_of(input logic [7:0] r, input logic x2);
    logic [CNT_W-1:0] span;
    span = CNT_W'(`DOP_RELOAD_TOP - r);
    if (r == `DOP_RELOAD_TOP) begin
      div_of = x2 ? CNT_W'(`DOP_DIV_X2_FAST) : CNT_W'(`DOP_DIV_STD_FAST);
    end else begin
      div_of = x2 ? (span << `DOP_DIV_X2_SHIFT) : (span << `DOP_DIV_STD_SHIFT);
    end
  endfunction

  always_comb begin
    logic [CNT_W-1:0] last;
    last         = div_of(reload_i, x2_i) - CNT_W'(1);
    cur_nxt      = cur_r;
    cur_nxt.tick = 1'b0;
    if (edge_i) begin
      if (cur_r.cnt >= last) begin
        cur_nxt.cnt  = '0;
        cur_nxt.tick = 1'b1;
      end else begin
        cur_nxt.cnt = cur_r.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cur_r <= '0;
    end else if (ce_i) begin
      cur_r <= cur_nxt;
    end
  end

  assign tick_o = cur_r.tick;
endmodule

/* File: testbench/dop_clock_power_ctrl_asserts.sv */
// checker for the clock and power control block, bound to its top
// assumes: sees only top-level ports; ce_i high in normal runs
`timescale 1ns/100ps
`include "dop_map.svh"
module dop_clock_power_ctrl_asserts
  import dop_pkg::*;
#(
  parameter int CNT_W = 10
) (
  input wire logic                  clk_i,
  input wire logic                  reset_i,
  input wire logic                  ce_i,
  input wire dop_pkg::dop_bus_req_t bus_i,
  input wire logic [7:0]            rdata_o,
  input wire logic                  fuse_osc_select_i,
  input wire logic                  power_up_i,
  input wire logic                  hf_osc_clk_i,
  input wire logic                  lf_osc_clk_i,
  input wire logic                  t0_pin_i,
  input wire logic                  ext_irq_a_n_i,
  input wire logic                  ext_irq_b_n_i,
  input wire logic                  ext_irq_a_en_i,
  input wire logic                  ext_irq_b_en_i,
  input wire logic                  kbd_wake_i,
  input wire logic                  irq_wake_i,
  input wire dop_pkg::dop_osc_ctl_t osc_o,
  input wire dop_pkg::dop_clk_out_t clk_o,
  input wire logic                  baud_doubler_o,
  input wire logic                  framing_view_select_o,
  input wire dop_pkg::dop_mode_t    mode_o
);
  // ==========
  // helpers: loading cycle and quiet wake pins
  logic       warm_q;
  logic [2:0] quiet_q;
  logic       wr_pc;
  logic       calm;
  assign wr_pc = ce_i && warm_q && bus_i.we && (bus_i.addr == `DOP_OFS_POWER_CTRL);
  assign calm  = (quiet_q == 3'h4) && ext_irq_a_n_i && ext_irq_b_n_i && !kbd_wake_i;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      warm_q  <= 1'b0;
      quiet_q <= 3'h0;
    end else begin
      warm_q  <= warm_q | ce_i;
      quiet_q <= !(ext_irq_a_n_i && ext_irq_b_n_i) ? 3'h0 : ((quiet_q == 3'h4) ? quiet_q : quiet_q + 3'h1);
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_baud_write: assert property (wr_pc |=> baud_doubler_o == $past(bus_i.wdata[7]))
    else $error("baud doubler does not follow write");
  a_fview_write: assert property (wr_pc |=> framing_view_select_o == $past(bus_i.wdata[6]))
    else $error("framing view does not follow write");
  a_idle_enter: assert property (wr_pc && bus_i.wdata[1:0] == 2'h1 && mode_o == DOP_NORMAL && calm && !irq_wake_i
    |=> mode_o == DOP_IDLE)
    else $error("idle not entered");
  a_pd_enter: assert property (wr_pc && bus_i.wdata[1] && calm
    |=> mode_o == DOP_PDOWN && osc_o.high_osc_stop && osc_o.low_osc_stop)
    else $error("power-down not entered");
  a_pd_stops: assert property (mode_o == DOP_PDOWN |-> osc_o.high_osc_stop && osc_o.low_osc_stop)
    else $error("oscillator runs in power-down");
  a_pd_holds: assert property (mode_o == DOP_PDOWN && calm && !wr_pc |=> mode_o == DOP_PDOWN)
    else $error("power-down left without wake");
  a_kbd_wake: assert property (mode_o == DOP_PDOWN && kbd_wake_i
    |=> mode_o == DOP_NORMAL && !(osc_o.high_osc_stop && osc_o.low_osc_stop))
    else $error("keyboard wake failed");
  a_idle_leave: assert property (mode_o == DOP_IDLE && irq_wake_i |=> mode_o == DOP_NORMAL)
    else $error("idle not left on interrupt");
  a_cpu_idle_off: assert property (mode_o != DOP_NORMAL && $past(mode_o) != DOP_NORMAL
    && $past(mode_o, 2) != DOP_NORMAL |-> !clk_o.cpu_clk_en)
    else $error("cpu clock runs outside normal");
  a_periph_pd_off: assert property (mode_o == DOP_PDOWN && $past(mode_o) == DOP_PDOWN
    && $past(mode_o, 2) == DOP_PDOWN |-> !clk_o.periph_clk_en)
    else $error("peripheral clock runs in power-down");
  a_fuse_load: assert property ($fell(reset_i) && ce_i |-> ##1
    (osc_o.high_osc_stop == !fuse_osc_select_i && osc_o.low_osc_stop == fuse_osc_select_i))
    else $error("oscillators not set from fuse");
  a_src_no_runt: assert property ($rose(clk_o.src_clk) |=> clk_o.src_clk)
    else $error("runt pulse on source clock");
endmodule
bind dop_clock_power_ctrl dop_clock_power_ctrl_asserts #(.CNT_W(CNT_W)) u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .fuse_osc_select_i(fuse_osc_select_i), .power_up_i(power_up_i), .hf_osc_clk_i(hf_osc_clk_i),
  .lf_osc_clk_i(lf_osc_clk_i), .t0_pin_i(t0_pin_i), .ext_irq_a_n_i(ext_irq_a_n_i),
  .ext_irq_b_n_i(ext_irq_b_n_i), .ext_irq_a_en_i(ext_irq_a_en_i), .ext_irq_b_en_i(ext_irq_b_en_i),
  .kbd_wake_i(kbd_wake_i), .irq_wake_i(irq_wake_i), .osc_o(osc_o), .clk_o(clk_o),
  .baud_doubler_o(baud_doubler_o), .framing_view_select_o(framing_view_select_o), .mode_o(mode_o));

/* File: testbench/dop_osc_model.sv */
// model of the two oscillator hard blocks
// assumes: half periods counted in system clock cycles
`timescale 1ns/100ps
module dop_osc_model
  import dop_pkg::*;
#(
  parameter int HF_HALF = 3,
  parameter int LF_HALF = 5
) (
  input  wire logic                  clk_i,
  input  wire dop_pkg::dop_osc_ctl_t osc_i,
  output logic                       hf_o,
  output logic                       lf_o
);
  int hf_cnt = 0;
  int lf_cnt = 0;
  initial begin
    hf_o = 1'b0;
    lf_o = 1'b0;
  end
  // ==========
  // stopped source parks low, restarts from phase zero
  always @(posedge clk_i) begin
    if (osc_i.high_osc_stop) begin
      hf_cnt <= 0;
      hf_o   <= 1'b0;
    end else if (hf_cnt == HF_HALF - 1) begin
      hf_cnt <= 0;
      hf_o   <= ~hf_o;
    end else begin
      hf_cnt <= hf_cnt + 1;
    end
    if (osc_i.low_osc_stop) begin
      lf_cnt <= 0;
      lf_o   <= 1'b0;
    end else if (lf_cnt == LF_HALF - 1) begin
      lf_cnt <= 0;
      lf_o   <= ~lf_o;
    end else begin
      lf_cnt <= lf_cnt + 1;
    end
  end
endmodule

/* File: testbench/dop_clock_power_ctrl_tb.sv */
// self-checking bench for the clock and power control block
// assumes: oscillator model at the far side, checker bound to the top
`timescale 1ns/100ps
module dop_clock_power_ctrl_tb;
  import dop_pkg::*;
  localparam int HP = 6;
  logic         clk_i   = 1'b0;
  logic         reset_i = 1'b1;
  logic         fuse_r  = 1'b1;
  logic         pwr_up  = 1'b1;
  logic         t0_pin  = 1'b0;
  logic         irq_a_n = 1'b1;
  logic         irq_b_n = 1'b1;
  logic         irq_a_en = 1'b1;
  logic         irq_b_en = 1'b1;
  logic         ce      = 1'b1;
  logic [2:0]   lf_d    = '0;
  logic [2:0]   t0_d    = '0;
  logic         kbd     = 1'b0;
  logic         irq     = 1'b0;
  logic         hf;
  logic         lf;
  dop_bus_req_t bus_r   = '0;
  logic [7:0]   rdata;
  dop_osc_ctl_t osc;
  dop_clk_out_t clko;
  logic         baud;
  logic         fview;
  dop_mode_t    mode;
  int           errors    = 0;
  int           cmp_count = 0;
  int           c;
  logic [7:0]   d;
  logic [7:0]   pr [5] = '{8'hFF, 8'hFF, 8'hFE, 8'h00, 8'hF8};
  logic         px [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) t0_pin <= 1'($urandom);
  always @(posedge clk_i) begin
    lf_d <= {lf_d[1:0], lf};
    t0_d <= {t0_d[1:0], t0_pin};
  end

  dop_clock_power_ctrl #(.CNT_W(10)) DUT (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce), .bus_i(bus_r), .rdata_o(rdata),
    .fuse_osc_select_i(fuse_r), .power_up_i(pwr_up), .hf_osc_clk_i(hf), .lf_osc_clk_i(lf),
    .t0_pin_i(t0_pin), .ext_irq_a_n_i(irq_a_n), .ext_irq_b_n_i(irq_b_n), .ext_irq_a_en_i(irq_a_en),
    .ext_irq_b_en_i(irq_b_en), .kbd_wake_i(kbd), .irq_wake_i(irq), .osc_o(osc), .clk_o(clko),
    .baud_doubler_o(baud), .framing_view_select_o(fview), .mode_o(mode));
  dop_osc_model #(.HF_HALF(3), .LF_HALF(5)) u_osc (.clk_i(clk_i), .osc_i(osc), .hf_o(hf), .lf_o(lf));

  // ==========
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i) bus_r <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
    @(posedge clk_i) bus_r.we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i) bus_r <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk_i) bus_r.re <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic wait_en(input bit per, output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while ((per ? clko.periph_clk_en : clko.cpu_clk_en) !== 1'b1 && n < 8000);
  endtask
  task automatic do_reset(input logic f);
    @(posedge clk_i);
    fuse_r  <= f;
    reset_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    tick(2);
  endtask
  task automatic t0_watch(input logic sub);
    repeat (12) begin
      tick(1);
      chk(clko.timer0_clk, sub ? lf_d[2] : t0_d[2]);
    end
  endtask
  function automatic int exp_div(input logic [7:0] r, input logic x2);
    if (r == 8'hFF) return x2 ? HP : 2 * HP;
    return (x2 ? 2 : 4) * (255 - int'(r)) * HP;
  endfunction
  task automatic report_and_stop;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clk_i);
    errors++;
    report_and_stop();
  end

  // ==========
  // main sequence
  initial begin
    void'($urandom(32));
    pr[4] = 8'hF0 + 8'($urandom % 15);
    do_reset(1'b1);
    tick(3);
    t0_watch(1'b0);
    rd(8'h86, 8'h01);
    rd(8'h85, 8'h01);
    rd(8'h97, 8'hFF);
    rd(8'h87, 8'h10);
    @(posedge clk_i) pwr_up <= 1'b0;
    wr(8'h90, 8'hFF);
    rd(8'h90, 8'h00);
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'hFC : 8'($urandom) & 8'hFC;
      wr(8'h87, d);
      rd(8'h87, d & 8'hDC);
      chk(baud, d[7]);
      chk(fview, d[6]);
      d = (i == 0) ? 8'h00 : 8'($urandom);
      wr(8'h97, d);
      rd(8'h97, d);
    end
    for (int i = 0; i < 5; i++) begin
      wr(8'h8F, {7'h00, px[i]});
      wr(8'h97, pr[i]);
      wait_en(1'b0, c);
      wait_en(1'b0, c);
      wait_en(1'b0, c);
      chk(c, exp_div(pr[i], px[i]));
    end
    wr(8'h8F, 8'h00);
    wr(8'h97, 8'hFF);
    wr(8'h87, 8'h02);
    tick(1);
    chk(mode, DOP_PDOWN);
    chk(osc, 2'b11);
    @(posedge clk_i) irq <= 1'b1;
    @(posedge clk_i) irq <= 1'b0;
    tick(2);
    chk(mode, DOP_PDOWN);
    @(posedge clk_i) kbd <= 1'b1;
    @(posedge clk_i) kbd <= 1'b0;
    tick(2);
    chk(mode, DOP_NORMAL);
    chk(osc.high_osc_stop, 1'b0);
    rd(8'h87, 8'h00);
    for (int k = 0; k < 2; k++) begin
      wr(8'h87, 8'h02);
      tick(3);
      @(posedge clk_i) {irq_a_n, irq_b_n, irq_a_en, irq_b_en} <= 4'h0;
      tick(10);
      chk(mode, DOP_PDOWN);
      @(posedge clk_i) {irq_a_en, irq_b_en} <= (k == 0) ? 2'b10 : 2'b01;
      tick(2);
      chk(mode, DOP_NORMAL);
      @(posedge clk_i) {irq_a_n, irq_b_n, irq_a_en, irq_b_en} <= 4'hF;
    end
    wr(8'h86, 8'h03);
    wr(8'h85, 8'h00);
    tick(30);
    wr(8'h87, 8'h01);
    tick(1);
    chk(mode, DOP_IDLE);
    wait_en(1'b1, c);
    wait_en(1'b1, c);
    chk(c, 20);
    @(posedge clk_i) irq <= 1'b1;
    @(posedge clk_i) irq <= 1'b0;
    tick(2);
    chk(mode, DOP_NORMAL);
    rd(8'h86, 8'h03);
    rd(8'h85, 8'h00);
    @(posedge clk_i) ce <= 1'b0;
    wr(8'h97, 8'h12);
    @(posedge clk_i) ce <= 1'b1;
    rd(8'h97, 8'hFF);
    wr(8'h86, 8'h07);
    rd(8'h86, 8'h07);
    t0_watch(1'b1);
    wr(8'h87, 8'h02);
    tick(4);
    do_reset(1'b0);
    rd(8'h86, 8'h02);
    rd(8'h85, 8'h00);
    rd(8'h87, 8'h00);
    tick(40);
    chk(osc, 2'b10);
    report_and_stop();
  end
endmodule
